// ### hdl/occ_output_compare.sv
// output compare unit: control, compare values, pulse and pwm generator, interrupts
// assumes timer counts and rollover pulses come from timers on ref_clk; fault pin is async
`timescale 1ns/1ps
// Summary of operation
// R1 - enable bit 15 turns the unit on; zero turns it off
// R2 - idle_stop set halts the unit while the chip idles
// R3 - wide select compares 32 bits, otherwise low 16 bits only
// R4 - fault flag set by hardware, read-only, never cleared by software write
// R5 - fault flag used only in mode 111, reads 0 otherwise
// R6 - timebase_select picks timebase_b when 1, timebase_a when 0
// R7 - modes 111 and 110 produce pwm, 111 honours the fault input
// R8 - mode 101 starts low and emits continuous pulses
// R9 - mode 100 starts low and emits exactly one pulse
// R10 - mode 011 toggles the pin on every match
// R11 - mode 010 starts high, match drives pin low
// R12 - mode 001 starts low, match drives pin high
// R13 - mode 000 disables comparing; a primary match still sets its status bit
// R14 - software avoids register access right after clearing enable
// R15 - control bits 12 to 6 read as zero
// R16 - pwm goes high at period rollover, low on secondary match
module occ_output_compare (
   input  wire logic        ref_clk,
   input  wire logic        rst,
   input  wire logic [7:0]  reg_addr,
   input  wire logic [31:0] reg_wdata,
   input  wire logic        reg_write,
   input  wire logic        reg_read,
   output logic [31:0]      reg_rdata,
   input  wire logic [31:0] timebase_a,
   input  wire logic [31:0] timebase_b,
   input  wire logic        rollover_a,
   input  wire logic        rollover_b,
   input  wire logic        chip_idle,
   input  wire logic        fault_pin,
   output logic             compare_output_pin,
   output logic             irq
);
   // ----------------------------------------------------------------
   // registers and wires
   // ----------------------------------------------------------------
   logic        enable_r;
   logic        idle_stop_r;
   logic        wide_r;
   logic        tb_sel_r;
   logic [2:0]  mode_r;
   logic        fault_r;
   logic        fault_nxt;
   logic [31:0] primary_r;
   logic [31:0] secondary_r;
   logic [2:0]  irq_stat_r;
   logic [2:0]  irq_stat_nxt;
   logic [2:0]  irq_en_r;
   logic [31:0] reg_rdata_r;
   logic        pin_r;
   logic        pin_nxt;
   logic [2:0]  mode_seen_r;
   logic        was_running_r;
   occ_pkg::occ_pulse_t pulse_r;
   occ_pkg::occ_pulse_t pulse_nxt;
   logic        fault_s1_r;
   logic        fault_s2_r;

   // ----------------------------------------------------------------
   // register decode
   // ----------------------------------------------------------------
   wire wr_control   = reg_write && (reg_addr == occ_pkg::ADDR_CONTROL);
   wire wr_primary   = reg_write && (reg_addr == occ_pkg::ADDR_PRIMARY);
   wire wr_secondary = reg_write && (reg_addr == occ_pkg::ADDR_SECONDARY);
   wire wr_irq_en    = reg_write && (reg_addr == occ_pkg::ADDR_IRQ_EN);
   wire wr_irq_clr   = reg_write && (reg_addr == occ_pkg::ADDR_IRQ_CLR);

   // fault flag shows only in the fault-honouring pwm mode
   wire fault_view = fault_r && (mode_r == occ_pkg::MODE_PWM_FLT); // R5

   // control word as read back; bits 12..6, 14 and 31..16 read zero
   wire [31:0] control_word = {16'h0000,
                               enable_r,
                               1'b0,
                               idle_stop_r,
                               7'h00, // R15
                               wide_r,
                               fault_view,
                               tb_sel_r,
                               mode_r};

   // read multiplexer; unmapped offsets read zero
   wire [31:0] rd_mux =
      (reg_addr == occ_pkg::ADDR_CONTROL)   ? control_word :
      (reg_addr == occ_pkg::ADDR_PRIMARY)   ? primary_r :
      (reg_addr == occ_pkg::ADDR_SECONDARY) ? secondary_r :
      (reg_addr == occ_pkg::ADDR_IRQ_STAT)  ? {29'h0000_0000, irq_stat_r} :
      (reg_addr == occ_pkg::ADDR_IRQ_EN)    ? {29'h0000_0000, irq_en_r} :
      32'h0000_0000;

   // ----------------------------------------------------------------
   // compare path
   // ----------------------------------------------------------------
   // running only when enabled and not halted by idle
   wire running  = enable_r && !(idle_stop_r && chip_idle); // R1 R2
   wire [31:0] count    = tb_sel_r ? timebase_b : timebase_a; // R6
   wire        rollover = tb_sel_r ? rollover_b : rollover_a; // R6
   wire [31:0] cmp_mask = wide_r ? 32'hFFFF_FFFF : 32'h0000_FFFF; // R3
   wire match_a = running && ((count & cmp_mask) == (primary_r & cmp_mask)); // R3
   wire match_b = running && ((count & cmp_mask) == (secondary_r & cmp_mask)); // R3
   wire is_pwm  = (mode_r == occ_pkg::MODE_PWM) || (mode_r == occ_pkg::MODE_PWM_FLT); // R7
   // a fresh start: unit just started or the mode changed
   wire restart = running && (!was_running_r || (mode_seen_r != mode_r));
   // fault only counts in the fault-honouring mode
   wire fault_hit = running && (mode_r == occ_pkg::MODE_PWM_FLT) && fault_s2_r; // R7

   // ----------------------------------------------------------------
   // output pin next value
   // ----------------------------------------------------------------
   always_comb begin
      pin_nxt   = pin_r;
      pulse_nxt = pulse_r;
      if (!running) begin
         pin_nxt   = pin_r;
         pulse_nxt = occ_pkg::OCC_IDLE;
      end else if (restart) begin
         // initial pin level for each mode
         pin_nxt   = (mode_r == occ_pkg::MODE_SET_LOW); // R11 R12 R8 R9
         pulse_nxt = occ_pkg::OCC_WAIT_A;
      end else begin
         case (mode_r)
            occ_pkg::MODE_OFF: begin
               pin_nxt = pin_r; // R13
            end
            occ_pkg::MODE_SET_HIGH: begin
               if (match_a) begin
                  pin_nxt = 1'b1; // R12
               end
            end
            occ_pkg::MODE_SET_LOW: begin
               if (match_a) begin
                  pin_nxt = 1'b0; // R11
               end
            end
            occ_pkg::MODE_TOGGLE: begin
               if (match_a) begin
                  pin_nxt = !pin_r; // R10
               end
            end
            occ_pkg::MODE_SINGLE, occ_pkg::MODE_CONT: begin
               // high on primary match, low on secondary match
               case (pulse_r)
                  occ_pkg::OCC_WAIT_A: begin
                     if (match_a) begin
                        pin_nxt   = 1'b1;
                        pulse_nxt = occ_pkg::OCC_WAIT_B;
                     end
                  end
                  occ_pkg::OCC_WAIT_B: begin
                     if (match_b) begin
                        pin_nxt   = 1'b0;
                        pulse_nxt = (mode_r == occ_pkg::MODE_CONT) ?
                                    occ_pkg::OCC_WAIT_A : occ_pkg::OCC_DONE; // R8 R9
                     end
                  end
                  occ_pkg::OCC_DONE: begin
                     pin_nxt = 1'b0; // R9
                  end
                  default: begin
                     pulse_nxt = occ_pkg::OCC_WAIT_A;
                  end
               endcase
            end
            occ_pkg::MODE_PWM, occ_pkg::MODE_PWM_FLT: begin
               // a latched fault only holds the pin low where the fault input is honoured
               if (fault_hit || (fault_r && mode_r == occ_pkg::MODE_PWM_FLT)) begin
                  pin_nxt = 1'b0; // R7
               end else if (match_b) begin
                  pin_nxt = 1'b0; // R16
               end else if (rollover) begin
                  pin_nxt = 1'b1; // R16
               end
            end
            default: begin
               pin_nxt = pin_r;
            end
         endcase
      end
   end

   // fault flag: set by fault, cleared by hardware when fault gone at rollover or when the mode is not pwm
   always_comb begin
      fault_nxt = fault_r;
      if (fault_hit) begin
         fault_nxt = 1'b1; // R4
      end else if (fault_r && is_pwm && rollover && !fault_s2_r) begin
         fault_nxt = 1'b0; // R4
      end else if (!is_pwm) begin
         fault_nxt = 1'b0;
      end
   end

   // sticky status: set beats the clear
   always_comb begin
      irq_stat_nxt = irq_stat_r;
      if (wr_irq_clr) begin
         irq_stat_nxt = irq_stat_r & ~reg_wdata[2:0];
      end
      irq_stat_nxt[occ_pkg::IRQ_MATCH_A] = irq_stat_nxt[occ_pkg::IRQ_MATCH_A] || match_a;
      irq_stat_nxt[occ_pkg::IRQ_MATCH_B] = irq_stat_nxt[occ_pkg::IRQ_MATCH_B] ||
                                           (match_b && mode_r != occ_pkg::MODE_OFF);
      irq_stat_nxt[occ_pkg::IRQ_FAULT]   = irq_stat_nxt[occ_pkg::IRQ_FAULT] ||
                                           (fault_hit && !fault_r);
   end

   // ----------------------------------------------------------------
   // flip-flops
   // ----------------------------------------------------------------
   // fault pin synchroniser
   always_ff @(posedge ref_clk) begin
      if (rst) begin
         fault_s1_r <= 1'b0;
         fault_s2_r <= 1'b0;
      end else begin
         fault_s1_r <= fault_pin;
         fault_s2_r <= fault_s1_r;
      end
   end

   // control register; fault bit ignores software writes
   always_ff @(posedge ref_clk) begin
      if (rst) begin
         enable_r    <= occ_pkg::CONTROL_RESET[occ_pkg::BIT_ENABLE];
         idle_stop_r <= occ_pkg::CONTROL_RESET[occ_pkg::BIT_IDLE_STOP];
         wide_r      <= occ_pkg::CONTROL_RESET[occ_pkg::BIT_WIDE];
         tb_sel_r    <= occ_pkg::CONTROL_RESET[occ_pkg::BIT_TB_SEL];
         mode_r      <= occ_pkg::CONTROL_RESET[2:0];
      end else if (wr_control) begin
         enable_r    <= reg_wdata[occ_pkg::BIT_ENABLE]; // R1
         idle_stop_r <= reg_wdata[occ_pkg::BIT_IDLE_STOP]; // R2
         wide_r      <= reg_wdata[occ_pkg::BIT_WIDE]; // R3
         tb_sel_r    <= reg_wdata[occ_pkg::BIT_TB_SEL]; // R6
         mode_r      <= reg_wdata[occ_pkg::MODE_LSB +: 3];
      end
   end

   // compare values
   always_ff @(posedge ref_clk) begin
      if (rst) begin
         primary_r   <= occ_pkg::VALUE_RESET;
         secondary_r <= occ_pkg::VALUE_RESET;
      end else begin
         if (wr_primary) begin
            primary_r <= reg_wdata;
         end
         if (wr_secondary) begin
            secondary_r <= reg_wdata;
         end
      end
   end

   // output state, fault flag and start tracking
   always_ff @(posedge ref_clk) begin
      if (rst) begin
         pin_r         <= 1'b0;
         pulse_r       <= occ_pkg::OCC_IDLE;
         fault_r       <= 1'b0;
         was_running_r <= 1'b0;
         mode_seen_r   <= occ_pkg::MODE_OFF;
      end else begin
         pin_r         <= pin_nxt;
         pulse_r       <= pulse_nxt;
         fault_r       <= fault_nxt;
         was_running_r <= running;
         mode_seen_r   <= mode_r;
      end
   end

   // interrupt registers and read data
   always_ff @(posedge ref_clk) begin
      if (rst) begin
         irq_stat_r  <= occ_pkg::IRQ_RESET;
         irq_en_r    <= occ_pkg::IRQ_RESET;
         reg_rdata_r <= 32'h0000_0000;
      end else begin
         irq_stat_r  <= irq_stat_nxt;
         if (wr_irq_en) begin
            irq_en_r <= reg_wdata[2:0];
         end
         reg_rdata_r <= reg_read ? rd_mux : 32'h0000_0000;
      end
   end

   // outputs
   assign reg_rdata          = reg_rdata_r;
   assign compare_output_pin = pin_r;
   assign irq                = |(irq_stat_r & irq_en_r);
endmodule

// ### hdl/occ_pkg.sv
// package for the output compare unit: register map, fields, modes, reset values
// assumes a plain register port with one-cycle strobes and read data one cycle later
package occ_pkg;
   // ----------------------------------------------------------------
   // register offsets (byte addresses)
   // ----------------------------------------------------------------
   localparam logic [7:0] ADDR_CONTROL   = 8'h00;
   localparam logic [7:0] ADDR_PRIMARY   = 8'h04;
   localparam logic [7:0] ADDR_SECONDARY = 8'h08;
   localparam logic [7:0] ADDR_IRQ_STAT  = 8'h0C;
   localparam logic [7:0] ADDR_IRQ_EN    = 8'h10;
   localparam logic [7:0] ADDR_IRQ_CLR   = 8'h14;
   // ----------------------------------------------------------------
   // control register fields
   // ----------------------------------------------------------------
   localparam int BIT_ENABLE    = 15;
   localparam int BIT_IDLE_STOP = 13;
   localparam int BIT_WIDE      = 5;
   localparam int BIT_FAULT     = 4;
   localparam int BIT_TB_SEL    = 3;
   localparam int MODE_LSB      = 0;
   localparam logic [31:0] CONTROL_RESET = 32'h0000_0000;
   localparam logic [31:0] VALUE_RESET   = 32'h0000_0000;
   localparam logic [2:0]  IRQ_RESET     = 3'h0;
   // interrupt status bits
   localparam int IRQ_MATCH_A = 0;
   localparam int IRQ_MATCH_B = 1;
   localparam int IRQ_FAULT   = 2;
   // ----------------------------------------------------------------
   // compare modes
   // ----------------------------------------------------------------
   localparam logic [2:0] MODE_OFF      = 3'h0;
   localparam logic [2:0] MODE_SET_HIGH = 3'h1;
   localparam logic [2:0] MODE_SET_LOW  = 3'h2;
   localparam logic [2:0] MODE_TOGGLE   = 3'h3;
   localparam logic [2:0] MODE_SINGLE   = 3'h4;
   localparam logic [2:0] MODE_CONT     = 3'h5;
   localparam logic [2:0] MODE_PWM      = 3'h6;
   localparam logic [2:0] MODE_PWM_FLT  = 3'h7;
   typedef enum logic [1:0] {OCC_IDLE, OCC_WAIT_A, OCC_WAIT_B, OCC_DONE} occ_pulse_t;
endpackage

// ### verification/occ_output_compare_checker.sv
// checker for the output compare unit, bound to its ports
// assumes one clock, synchronous reset, shadow copies taken from the register port
`timescale 1ns/1ps
module occ_output_compare_checker (
   input wire logic        ref_clk,
   input wire logic        rst,
   input wire logic [7:0]  reg_addr,
   input wire logic [31:0] reg_wdata,
   input wire logic        reg_write,
   input wire logic        reg_read,
   input wire logic [31:0] reg_rdata,
   input wire logic [31:0] timebase_a,
   input wire logic [31:0] timebase_b,
   input wire logic        rollover_a,
   input wire logic        rollover_b,
   input wire logic        chip_idle,
   input wire logic        fault_pin,
   input wire logic        compare_output_pin,
   input wire logic        irq
);
   logic [31:0] ctl_r, ctl_q, ctl_qq, prim_r, cnt;
   logic        hit, calm, on;
   // shadow control and primary value, plus two older control copies
   always_ff @(posedge ref_clk) begin
      ctl_q  <= rst ? 32'h0 : ctl_r;
      ctl_qq <= rst ? 32'h0 : ctl_q;
      if (rst) begin
         ctl_r  <= 32'h0;
         prim_r <= 32'h0;
      end else if (reg_write && reg_addr == occ_pkg::ADDR_CONTROL) begin
         ctl_r <= reg_wdata;
      end else if (reg_write && reg_addr == occ_pkg::ADDR_PRIMARY) begin
         prim_r <= reg_wdata;
      end
   end
   // selected count, primary match, settled control with no restart pending
   assign cnt  = ctl_r[3] ? timebase_b : timebase_a;
   assign hit  = ctl_r[5] ? cnt == prim_r : cnt[15:0] == prim_r[15:0];
   assign calm = ctl_r == ctl_q && ctl_q == ctl_qq;
   assign on   = ctl_r[15] && !ctl_r[13] && calm;
   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (rst);
   // -----------------------------------------------------------------
   // assertions
   // -----------------------------------------------------------------
   chk_reserved_read_zero: assert property (
      $past(reg_read) && $past(reg_addr) == occ_pkg::ADDR_CONTROL
      |-> (reg_rdata & 32'hFFFF_5FC0) == 32'h0) else $error("reserved control bits set");
   chk_fault_flag_hidden: assert property (
      $past(reg_read) && $past(reg_addr) == occ_pkg::ADDR_CONTROL && reg_rdata[2:0] != 3'h7
      |-> !reg_rdata[4]) else $error("fault flag seen outside mode 111");
   chk_off_holds_pin: assert property (
      (!ctl_r[15] || ctl_r[2:0] == 3'h0) && calm |-> $stable(compare_output_pin))
      else $error("pin moved while the unit is off");
   chk_idle_holds_pin: assert property (
      (ctl_r[15] && ctl_r[13] && calm && chip_idle) [*3] |-> $stable(compare_output_pin))
      else $error("pin moved while stopped in idle");
   chk_set_high_match: assert property (
      on && ctl_r[2:0] == 3'h1 && hit |=> compare_output_pin) else $error("no high on match");
   chk_set_low_match: assert property (
      on && ctl_r[2:0] == 3'h2 && hit |=> !compare_output_pin) else $error("no low on match");
   chk_toggle_on_match: assert property (
      on && ctl_r[2:0] == 3'h3 && hit |=> compare_output_pin != $past(compare_output_pin))
      else $error("pin did not toggle on match");
   chk_fault_forces_low: assert property (
      (on && ctl_r[2:0] == 3'h7 && fault_pin) [*4] |=> !compare_output_pin)
      else $error("fault did not force the pin low");
   cov_single: cover property (on && ctl_r[2:0] == 3'h4 && hit);
   cov_fault: cover property (on && ctl_r[2:0] == 3'h7 && fault_pin);
   cov_irq: cover property ($rose(irq));
endmodule
bind occ_output_compare occ_output_compare_checker u_occ_output_compare_checker (
   .ref_clk, .rst, .reg_addr, .reg_wdata, .reg_write, .reg_read, .reg_rdata, .timebase_a,
   .timebase_b, .rollover_a, .rollover_b, .chip_idle, .fault_pin, .compare_output_pin, .irq);

// ### verification/occ_load_model.sv
// load on the compare output: counts rising steps of the pin
// assumes the pin is sampled on ref_clk
`timescale 1ns/1ps
module occ_load_model (
   input wire logic ref_clk,
   input wire logic rst,
   input wire logic pin,
   output int       edges
);
   logic last_r;
   // count low to high steps, cleared by reset
   always_ff @(posedge ref_clk) begin
      last_r <= pin;
      edges  <= rst ? 0 : edges + int'(pin && !last_r);
   end
endmodule

// ### verification/occ_output_compare_bench.sv
// bench for the output compare unit: mode table, then hand-written cases
// assumes the load model counts pin pulses; timers are driven by the bench
`timescale 1ns/1ps
module occ_output_compare_bench;
   typedef struct packed {
      logic [2:0]  mode;
      logic        sel;
      logic        wide;
      logic [31:0] cnt;
      logic        init;
      logic        after;
   } occ_row_t;
   logic        ref_clk = 0, rst = 1, reg_write = 0, reg_read = 0, ra = 0, rb = 0;
   logic        idle = 0, flt = 0, pin, irq;
   logic [7:0]  reg_addr = 8'h00;
   logic [31:0] reg_wdata = 32'h0, ta = 32'h0, tb = 32'h0, reg_rdata;
   int          mismatches = 0, checks = 0, cycles = 0, edges, e0;
   occ_row_t    rows [5] = '{'{3'h0, 1'b0, 1'b0, 32'h0000_0005, 1'b0, 1'b0},
      '{3'h1, 1'b0, 1'b0, 32'h0000_0005, 1'b0, 1'b1}, '{3'h2, 1'b1, 1'b0, 32'h0007_0005, 1'b1, 1'b0},
      '{3'h1, 1'b1, 1'b1, 32'h0000_0005, 1'b0, 1'b0}, '{3'h3, 1'b0, 1'b1, 32'h0001_0005, 1'b0, 1'b1}};
   occ_output_compare u_occ_output_compare (.ref_clk(ref_clk), .rst(rst), .reg_addr(reg_addr),
      .reg_wdata(reg_wdata), .reg_write(reg_write), .reg_read(reg_read), .reg_rdata(reg_rdata),
      .timebase_a(ta), .timebase_b(tb), .rollover_a(ra), .rollover_b(rb), .chip_idle(idle),
      .fault_pin(flt), .compare_output_pin(pin), .irq(irq));
   occ_load_model u_occ_load_model (.ref_clk(ref_clk), .rst(rst), .pin(pin), .edges(edges));
   // -----------------------------------------------------------------
   // clock, cycle limit and closing report
   // -----------------------------------------------------------------
   initial forever #20 ref_clk = ~ref_clk;
   always @(posedge ref_clk) begin
      cycles++;
      if (cycles == 3000) begin
         mismatches++;
         conclude();
      end
   end
   task automatic conclude;
      if (mismatches == 0 && checks > 0)
         $display("TEST PASSED");
      else
         $display("TEST FAILED");
      $finish;
   endtask
   // -----------------------------------------------------------------
   // bus, timer and compare tasks
   // -----------------------------------------------------------------
   task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
      checks++;
      if (g !== e) begin
         mismatches++;
         $display("Error %s expected %h seen %h", n, e, g);
      end
   endtask
   task automatic pk(input logic e);
      chk("pin", {31'h0, e}, {31'h0, pin});
   endtask
   task automatic tick(input int n);
      repeat (n) @(posedge ref_clk);
      #1;
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] v);
      @(posedge ref_clk);
      {reg_write, reg_addr, reg_wdata} <= {1'b1, a, v};
      @(posedge ref_clk);
      reg_write <= 1'b0;
   endtask
   task automatic rd(input logic [7:0] a, input logic [31:0] e, input string n);
      @(posedge ref_clk);
      {reg_read, reg_addr} <= {1'b1, a};
      @(posedge ref_clk);
      reg_read <= 1'b0;
      #1;
      chk(n, e, reg_rdata);
   endtask
   // one-cycle count on the selected timer, neighbour value on the other
   task automatic hit(input logic [31:0] c, input logic s);
      @(posedge ref_clk);
      ta <= s ? c + 32'h1 : c;
      tb <= s ? c : c + 32'h1;
      @(posedge ref_clk);
      {ta, tb} <= 64'h0;
      tick(1);
   endtask
   task automatic roll(input logic s);
      @(posedge ref_clk);
      {ra, rb} <= {!s, s};
      @(posedge ref_clk);
      {ra, rb} <= 2'b00;
      tick(1);
   endtask
   task automatic ctl(input logic [31:0] v);
      wr(occ_pkg::ADDR_CONTROL, 32'h0);
      tick(1);
      wr(occ_pkg::ADDR_CONTROL, v);
      tick(2);
   endtask
   // -----------------------------------------------------------------
   // main sequence
   // -----------------------------------------------------------------
   initial begin
      tick(20);
      rst <= 1'b0;
      for (int i = 0; i < 7; i++) rd(8'(4 * i), 32'h0, "reset value");
      wr(occ_pkg::ADDR_IRQ_STAT, 32'hFFFF_FFFF);
      rd(occ_pkg::ADDR_IRQ_STAT, 32'h0, "status write");
      wr(occ_pkg::ADDR_CONTROL, 32'hFFFF_FFFF);
      rd(occ_pkg::ADDR_CONTROL, 32'h0000_A02F, "control");
      wr(occ_pkg::ADDR_PRIMARY, 32'h0001_0005);
      wr(occ_pkg::ADDR_SECONDARY, 32'h0000_0009);
      rd(occ_pkg::ADDR_PRIMARY, 32'h0001_0005, "primary");
      foreach (rows[i]) begin
         ctl({16'h0, 8'h80, 2'b00, rows[i].wide, 1'b0, rows[i].sel, rows[i].mode});
         pk(rows[i].init);
         hit(rows[i].cnt, rows[i].sel);
         pk(rows[i].after);
      end
      // single and continuous pulses
      ctl(32'h0000_8004);
      e0 = edges;
      hit(32'h5, 1'b0);
      hit(32'h9, 1'b0);
      hit(32'h5, 1'b0);
      chk("single pulses", 32'h1, 32'(edges - e0));
      pk(1'b0);
      ctl(32'h0000_8005);
      e0 = edges;
      repeat (2) begin
         hit(32'h5, 1'b0);
         hit(32'h9, 1'b0);
      end
      chk("continuous pulses", 32'h2, 32'(edges - e0));
      // pwm with and without the fault input
      ctl(32'h0000_8006);
      roll(1'b0);
      pk(1'b1);
      hit(32'h9, 1'b0);
      pk(1'b0);
      ctl(32'h0000_800F);
      roll(1'b1);
      pk(1'b1);
      @(posedge ref_clk) flt <= 1'b1;
      tick(5);
      pk(1'b0);
      rd(occ_pkg::ADDR_CONTROL, 32'h0000_801F, "fault flag");
      wr(occ_pkg::ADDR_CONTROL, 32'h0000_800F);
      rd(occ_pkg::ADDR_CONTROL, 32'h0000_801F, "fault flag kept");
      wr(occ_pkg::ADDR_CONTROL, 32'h0000_800E);
      rd(occ_pkg::ADDR_CONTROL, 32'h0000_800E, "fault flag hidden");
      roll(1'b1);
      pk(1'b1);
      @(posedge ref_clk) flt <= 1'b0;
      // interrupt raise, mask and clear
      rd(occ_pkg::ADDR_IRQ_STAT, 32'h7, "status all");
      ctl(32'h0);
      wr(occ_pkg::ADDR_IRQ_CLR, 32'h7);
      wr(occ_pkg::ADDR_IRQ_EN, 32'h1);
      ctl(32'h0000_8001);
      hit(32'h5, 1'b0);
      rd(occ_pkg::ADDR_IRQ_STAT, 32'h1, "status");
      chk("irq raised", 32'h1, {31'h0, irq});
      wr(occ_pkg::ADDR_IRQ_EN, 32'h0);
      tick(1);
      chk("irq masked", 32'h0, {31'h0, irq});
      wr(occ_pkg::ADDR_IRQ_EN, 32'h1);
      wr(occ_pkg::ADDR_IRQ_CLR, 32'h1);
      tick(1);
      chk("irq cleared", 32'h0, {31'h0, irq});
      rd(occ_pkg::ADDR_IRQ_STAT, 32'h0, "status cleared");
      // idle stop halts the toggle, idle run keeps it going
      ctl(32'h0000_A003);
      @(posedge ref_clk) idle <= 1'b1;
      tick(2);
      hit(32'h5, 1'b0);
      pk(1'b0);
      wr(occ_pkg::ADDR_CONTROL, 32'h0000_8003);
      tick(2);
      hit(32'h5, 1'b0);
      pk(1'b1);
      conclude();
   end
endmodule
